// >>> pkg/usb_ep_flags_defs.svh
// offsets, field positions, reset values and sizes of the endpoint flag block
`ifndef USB_EP_FLAGS_DEFS_SVH
`define USB_EP_FLAGS_DEFS_SVH

// ****************************************************************
// sizes
// ****************************************************************
`define EP_COUNT          4
`define EP_NUM_W          2
`define APB_ADDR_W        8
`define APB_DATA_W        32

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFF_EP_SELECT     8'h00
`define OFF_EP_STATUS     8'h04
`define OFF_EP_TYPE       8'h08
`define OFF_IRQ_ENABLE    8'h0c
`define OFF_IRQ_FLAGS     8'h10

// ****************************************************************
// endpoint status field positions
// ****************************************************************
`define BIT_IN_SENT       0
`define BIT_OUT_RECEIVED  1
`define BIT_SETUP_RECEIVED 2
`define STATUS_W          3

// ****************************************************************
// reset values
// ****************************************************************
`define RST_STATUS        3'h0
`define RST_EP_SELECT     2'h0
`define RST_IRQ_ENABLE    4'h0
`define RST_IRQ_FLAGS     4'h0

`endif

// >>> pkg/usb_ep_flags_pkg.sv
// types shared by the endpoint flag block
package usb_ep_flags_pkg;

    // transfer type of an endpoint, as held in the type register
    typedef enum logic [1:0] {
        EP_CONTROL   = 2'h0,
        EP_ISO       = 2'h1,
        EP_BULK      = 2'h2,
        EP_INTERRUPT = 2'h3
    } ep_type_t;

    typedef logic [1:0] ep_num_t;

endpackage

// >>> hdl/apb_reg_port.sv
// apb slave front end: phase tracking, registered read data, error answer
`timescale 1ns/1ps
`include "usb_ep_flags_defs.svh"

module apb_reg_port
(
    input  wire logic        ref_clk,   // controller clock
    input  wire logic        arst_n,    // async reset, active low
    input  wire logic        psel,      // apb select
    input  wire logic        penable,   // apb access phase
    input  wire logic        pwrite,    // apb direction
    input  wire logic [31:0] rd_word,   // read mux of current address
    input  wire logic        addr_ok,   // current address is mapped
    output logic      [31:0] prdata,    // apb read data
    output logic             pready,    // apb ready
    output logic             pslverr,   // apb error
    output logic             wr_stb     // one-cycle write commit
);
    import usb_ep_flags_pkg::*;

    logic [31:0] prdata_r;
    logic        err_r;
    logic        setup_ph;

    // setup phase: psel without penable
    assign setup_ph = psel & ~penable;

    // read data and error caught in the setup phase
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prdata_r <= 32'h0000_0000;
        end
        else if (setup_ph)
        begin
            prdata_r <= (!pwrite && addr_ok) ? rd_word : 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            err_r <= 1'b0;
        end
        else if (setup_ph)
        begin
            err_r <= ~addr_ok;
        end
    end

    // zero wait states: access phase always completes
    assign pready  = psel & penable;
    assign pslverr = pready & err_r;
    assign prdata  = prdata_r;
    assign wr_stb  = pready & pwrite & ~err_r;
endmodule

// >>> hdl/ep_flag_cell.sv
// status flags of one endpoint: setup, out and in-sent
`timescale 1ns/1ps
`include "usb_ep_flags_defs.svh"

module ep_flag_cell
(
    input  wire logic                 ref_clk,   // controller clock
    input  wire logic                 arst_n,    // async reset, active low
    input  wire logic                 setup_ev,  // valid setup received
    input  wire logic                 out_ev,    // out data accepted
    input  wire logic                 in_ev,     // in packet completed
    input  wire logic [`STATUS_W-1:0] sw_clr,    // firmware clear per bit
    output logic      [`STATUS_W-1:0] flags,     // current flags
    output logic                      trig       // pulse: a flag was set
);
    import usb_ep_flags_pkg::*;

    logic [`STATUS_W-1:0] flags_r;
    logic [`STATUS_W-1:0] flags_nxt;

    // next flags; hardware set beats firmware clear
    always_comb
    begin
        flags_nxt = flags_r & ~sw_clr;                          // RL13
        if (out_ev)
        begin
            flags_nxt[`BIT_OUT_RECEIVED] = 1'b1;                // RL3
        end
        if (in_ev)
        begin
            flags_nxt[`BIT_IN_SENT] = 1'b1;                     // RL7
        end
        if (setup_ev)
        begin
            flags_nxt = `RST_STATUS;                            // RL2
            flags_nxt[`BIT_SETUP_RECEIVED] = 1'b1;              // RL1
        end
    end

    // flag storage, zero after reset
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            flags_r <= `RST_STATUS;                             // RL10
        end
        else
        begin
            flags_r <= flags_nxt;
        end
    end

    assign flags = flags_r;
    assign trig  = setup_ev | out_ev | in_ev;                   // RL9
endmodule

// >>> hdl/usb_endpoint_status_flags.sv
// per-endpoint status flags, out nack control and endpoint interrupts
// ****************************************************************
// What this block does
// (RL1) setup received sets status bit two
// (RL2) setup received clears other status bits
// (RL3) out data received sets status bit one
// (RL4) further outs nacked while out flag set
// (RL5) setup never blocked by out flag
// (RL6) firmware clears out flag after reading
// (RL7) iso endpoint: in sent sets bit zero
// (RL8) other endpoints: bit zero after host ack
// (RL9) any flag set raises enabled endpoint interrupt
// (RL10) status reads zero after reset
// (RL11) firmware clears setup flag after reading
// (RL12) enabled trigger sets per-endpoint flag, firmware clears
// (RL13) flags sticky; writing zero clears only that flag
// ****************************************************************
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "usb_ep_flags_defs.svh"

module usb_endpoint_status_flags
(
    input  wire logic                     ref_clk,   // 250 MHz clock
    input  wire logic                     arst_n,    // async reset, low
    input  wire logic                     psel,      // apb select
    input  wire logic                     penable,   // apb enable
    input  wire logic                     pwrite,    // apb write
    input  wire logic [`APB_ADDR_W-1:0]   paddr,     // apb byte address
    input  wire logic [`APB_DATA_W-1:0]   pwdata,    // apb write data
    output logic      [`APB_DATA_W-1:0]   prdata,    // apb read data
    output logic                          pready,    // apb ready
    output logic                          pslverr,   // apb error
    input  wire usb_ep_flags_pkg::ep_num_t tok_ep,   // endpoint of token
    input  wire logic                     setup_rx,  // valid setup pulse
    input  wire logic                     out_rx,    // good out data pulse
    input  wire logic                     in_sent,   // in packet sent pulse
    input  wire logic                     in_acked,  // host ack of in pulse
    output logic                          out_nack,  // nack out to tok_ep
    output logic                          irq        // level interrupt
);
    import usb_ep_flags_pkg::*;

    // ****************************************************************
    // helper functions
    // ****************************************************************

    // address match against a register offset
    function automatic logic reg_hit(input logic [`APB_ADDR_W-1:0] a,
                                     input logic [`APB_ADDR_W-1:0] off);
        reg_hit = (a == off);
    endfunction

    // one-hot decode of an endpoint number
    function automatic logic [`EP_COUNT-1:0] ep_onehot(input ep_num_t n);
        ep_onehot = `EP_COUNT'(1) << n;
    endfunction

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic [`APB_DATA_W-1:0]  rd_word;
    logic                    addr_ok;
    logic                    wr_stb;
    ep_num_t                 ep_sel_r;
    ep_type_t                ep_type_r [`EP_COUNT];
    logic [`EP_COUNT-1:0]    irq_en_r;
    logic [`EP_COUNT-1:0]    irq_flags_r;
    logic [`EP_COUNT-1:0]    irq_flags_nxt;
    logic [`STATUS_W-1:0]    ep_flags [`EP_COUNT];
    logic [`EP_COUNT-1:0]    ep_trig;
    logic [`EP_COUNT-1:0]    tok_hot;
    logic [`EP_COUNT-1:0]    sel_hot;
    logic                    wr_select;
    logic                    wr_status;
    logic                    wr_type;
    logic                    wr_enable;
    logic                    wr_flags;

    // ****************************************************************
    // apb front end
    // ****************************************************************

    // mapped addresses
    assign addr_ok = reg_hit(paddr, `OFF_EP_SELECT)
                   | reg_hit(paddr, `OFF_EP_STATUS)
                   | reg_hit(paddr, `OFF_EP_TYPE)
                   | reg_hit(paddr, `OFF_IRQ_ENABLE)
                   | reg_hit(paddr, `OFF_IRQ_FLAGS);

    apb_reg_port u_apb
    (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .rd_word (rd_word),
        .addr_ok (addr_ok),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .wr_stb  (wr_stb)
    );

    // write strobes per register
    assign wr_select = wr_stb & reg_hit(paddr, `OFF_EP_SELECT);
    assign wr_status = wr_stb & reg_hit(paddr, `OFF_EP_STATUS);
    assign wr_type   = wr_stb & reg_hit(paddr, `OFF_EP_TYPE);
    assign wr_enable = wr_stb & reg_hit(paddr, `OFF_IRQ_ENABLE);
    assign wr_flags  = wr_stb & reg_hit(paddr, `OFF_IRQ_FLAGS);

    // read mux; unused high bits read zero
    always_comb
    begin
        rd_word = 32'h0000_0000;
        unique case (1'b1)
            reg_hit(paddr, `OFF_EP_SELECT):
                rd_word[`EP_NUM_W-1:0] = ep_sel_r;
            reg_hit(paddr, `OFF_EP_STATUS):
                rd_word[`STATUS_W-1:0] = ep_flags[ep_sel_r];
            reg_hit(paddr, `OFF_EP_TYPE):
                rd_word[1:0] = ep_type_r[ep_sel_r];
            reg_hit(paddr, `OFF_IRQ_ENABLE):
                rd_word[`EP_COUNT-1:0] = irq_en_r;
            reg_hit(paddr, `OFF_IRQ_FLAGS):
                rd_word[`EP_COUNT-1:0] = irq_flags_r;
            default:
                rd_word = 32'h0000_0000;
        endcase
    end

    // ****************************************************************
    // control registers
    // ****************************************************************

    // endpoint select for status and type access
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ep_sel_r <= `RST_EP_SELECT;
        end
        else if (wr_select)
        begin
            ep_sel_r <= pwdata[`EP_NUM_W-1:0];
        end
    end

    // transfer type of each endpoint, control after reset
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < `EP_COUNT; i++)
            begin
                ep_type_r[i] <= EP_CONTROL;
            end
        end
        else if (wr_type)
        begin
            ep_type_r[ep_sel_r] <= ep_type_t'(pwdata[1:0]);
        end
    end

    // endpoint interrupt enables
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_en_r <= `RST_IRQ_ENABLE;
        end
        else if (wr_enable)
        begin
            irq_en_r <= pwdata[`EP_COUNT-1:0];
        end
    end

    // ****************************************************************
    // endpoint flag cells
    // ****************************************************************
    assign tok_hot = ep_onehot(tok_ep);
    assign sel_hot = ep_onehot(ep_sel_r);

    for (genvar g = 0; g < `EP_COUNT; g++)
    begin : g_ep
        logic                 setup_ev;
        logic                 out_ev;
        logic                 in_ev;
        logic [`STATUS_W-1:0] sw_clr;
        logic                 is_iso;

        assign is_iso = (ep_type_r[g] == EP_ISO);

        // setup always taken, even with out flag set
        assign setup_ev = setup_rx & tok_hot[g];                // RL5
        // out data is only taken while not blocked
        assign out_ev   = out_rx & tok_hot[g]
                        & ~ep_flags[g][`BIT_OUT_RECEIVED];      // RL4
        // in completion: sent for iso, acked otherwise
        assign in_ev    = tok_hot[g]
                        & (is_iso ? in_sent : in_acked);        // RL7 RL8
        // zeros written to the selected status clear flags
        assign sw_clr   = (wr_status & sel_hot[g])
                        ? ~pwdata[`STATUS_W-1:0]
                        : `RST_STATUS;                          // RL13

        ep_flag_cell u_cell
        (
            .ref_clk  (ref_clk),
            .arst_n   (arst_n),
            .setup_ev (setup_ev),
            .out_ev   (out_ev),
            .in_ev    (in_ev),
            .sw_clr   (sw_clr),
            .flags    (ep_flags[g]),
            .trig     (ep_trig[g])
        );
    end

    // ****************************************************************
    // usb side handshake decision
    // ****************************************************************

    // nack further outs while the out flag is set
    assign out_nack = ep_flags[tok_ep][`BIT_OUT_RECEIVED];      // RL4

    // ****************************************************************
    // endpoint interrupt flags
    // ****************************************************************

    // set by enabled trigger, write one to clear, set wins
    always_comb
    begin
        irq_flags_nxt = irq_flags_r;
        if (wr_flags)
        begin
            irq_flags_nxt = irq_flags_nxt & ~pwdata[`EP_COUNT-1:0];
        end
        irq_flags_nxt = irq_flags_nxt | (ep_trig & irq_en_r);   // RL9 RL12
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_flags_r <= `RST_IRQ_FLAGS;
        end
        else
        begin
            irq_flags_r <= irq_flags_nxt;
        end
    end

    // level interrupt while any enabled flag stands
    assign irq = |(irq_flags_r & irq_en_r);                     // RL9
endmodule

// >>> testbench/usb_host_model.sv
// host side model: token endpoint and one-cycle packet events
`timescale 1ns/1ps
module usb_host_model
(
    input  wire logic                      ref_clk,  // clock
    input  wire logic                      arst_n,   // reset, low
    input  wire logic                      req,      // send one packet
    input  wire logic [1:0]                kind,     // 0 setup 1 out 2 in 3 ack
    input  wire usb_ep_flags_pkg::ep_num_t ep,       // target endpoint
    output usb_ep_flags_pkg::ep_num_t      tok_ep,   // token endpoint
    output logic                           setup_rx, // setup seen
    output logic                           out_rx,   // out data seen
    output logic                           in_sent,  // in packet sent
    output logic                           in_acked  // in packet acked
);
    import usb_ep_flags_pkg::*;
    // one packet per request; endpoint kept as last token
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tok_ep   <= 2'h0;
            setup_rx <= 1'h0;
            out_rx   <= 1'h0;
            in_sent  <= 1'h0;
            in_acked <= 1'h0;
        end
        else
        begin
            tok_ep   <= req ? ep : tok_ep;
            setup_rx <= req && kind == 2'h0;
            out_rx   <= req && kind == 2'h1;
            in_sent  <= req && kind == 2'h2;
            in_acked <= req && kind == 2'h3;
        end
    end
endmodule

// >>> testbench/usb_ep_flags_assertions.sv
// concurrent checks on the endpoint flag block ports
`timescale 1ns/1ps
module usb_ep_flags_assertions
(
    input wire logic                      ref_clk,  // clock
    input wire logic                      arst_n,   // reset, low
    input wire logic                      psel,     // apb select
    input wire logic                      penable,  // apb enable
    input wire logic                      pwrite,   // apb write
    input wire usb_ep_flags_pkg::ep_num_t tok_ep,   // event endpoint
    input wire logic                      setup_rx, // setup pulse
    input wire logic                      out_rx,   // out pulse
    input wire logic                      in_sent,  // in sent pulse
    input wire logic                      in_acked, // in ack pulse
    input wire logic                      out_nack, // nack level
    input wire logic                      irq       // interrupt
);
    import usb_ep_flags_pkg::*;
    logic wr;
    // firmware write commit
    assign wr = psel && penable && pwrite;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    property p_out_nack;
        out_rx && !setup_rx |=> tok_ep != $past(tok_ep) || out_nack;
    endproperty
    a_out_nack: assert property (p_out_nack)
        else $error("out packet did not block further outs");
    property p_setup_clr;
        setup_rx |=> tok_ep != $past(tok_ep) || !out_nack;
    endproperty
    a_setup_clr: assert property (p_setup_clr)
        else $error("setup left out flag set");
    property p_nack_hold;
        out_nack && !setup_rx && !wr ##1 $stable(tok_ep) |-> out_nack;
    endproperty
    a_nack_hold: assert property (p_nack_hold)
        else $error("out nack dropped without clear");
    property p_nack_rise;
        $rose(out_nack) |-> $past(out_rx) || $changed(tok_ep);
    endproperty
    a_nack_rise: assert property (p_nack_rise)
        else $error("out nack rose without out packet");
    property p_in_no_nack;
        (in_sent || in_acked) && !out_rx && !out_nack ##1 $stable(tok_ep)
            |-> !out_nack;
    endproperty
    a_in_no_nack: assert property (p_in_no_nack)
        else $error("in event touched out flag");
    property p_irq_rise;
        $rose(irq) |-> $past(setup_rx || out_rx || in_sent || in_acked || wr);
    endproperty
    a_irq_rise: assert property (p_irq_rise)
        else $error("interrupt rose without cause");
    property p_irq_hold;
        irq && !wr |=> irq;
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("interrupt dropped without firmware write");
    property p_reset;
        $rose(arst_n) |-> !irq && !out_nack;
    endproperty
    a_reset: assert property (p_reset)
        else $error("flags not clear after reset");
endmodule

bind usb_endpoint_status_flags usb_ep_flags_assertions i_chk
(
    .ref_clk, .arst_n, .psel, .penable, .pwrite, .tok_ep, .setup_rx,
    .out_rx, .in_sent, .in_acked, .out_nack, .irq
);

// >>> testbench/usb_endpoint_status_flags_tb.sv
// self-checking bench of the endpoint flag block
`timescale 1ns/1ps
module usb_endpoint_status_flags_tb;
    import usb_ep_flags_pkg::*;
    logic        ref_clk, arst_n, psel, penable, pwrite, req, e;
    logic        pready, pslverr, out_nack, irq;
    logic        setup_rx, out_rx, in_sent, in_acked;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q, r;
    logic [1:0]  kind;
    logic [2:0]  st [4];
    ep_num_t     ep, tok_ep, x;
    int          err_count, checks, seed, n, i;

    initial
    begin
        ref_clk = 1'h0;
        forever #2 ref_clk = ~ref_clk;
    end

    usb_endpoint_status_flags i_dut (.ref_clk, .arst_n, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tok_ep,
        .setup_rx, .out_rx, .in_sent, .in_acked, .out_nack, .irq);
    usb_host_model i_host (.ref_clk, .arst_n, .req, .kind, .ep, .tok_ep,
        .setup_rx, .out_rx, .in_sent, .in_acked);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        // only the watchdog ends a wait for pready
        do
        begin
            @(posedge ref_clk);
        end
        while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(q, exp);
        chk(e, 32'h0);
    endtask

    // one host packet, then wait until the flag has landed
    task automatic ev(input logic [1:0] kd, input ep_num_t t);
        req  <= 1'h1;
        kind <= kd;
        ep   <= t;
        @(posedge ref_clk);
        req <= 1'h0;
        repeat (2) @(posedge ref_clk);
    endtask

    // expected status after an event; endpoint type equals its number
    function automatic logic [2:0] fx(logic [2:0] s, logic [1:0] kd,
                                      logic [1:0] t);
        case (kd)
            2'h0: fx = 3'h4;
            2'h1: fx = s | 3'h2;
            2'h2: fx = (t == 2'h1) ? s | 3'h1 : s;
            default: fx = (t != 2'h1) ? s | 3'h1 : s;
        endcase
    endfunction

    task tally_and_finish();
        $display("checks=%0d mismatches=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        #40000;
        err_count++;
        tally_and_finish();
    end

    initial
    begin
        {arst_n, psel, penable, pwrite, req, kind, ep, paddr, pwdata} = '0;
        err_count = 0;
        checks = 0;
        seed = 63048;
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'h1;
        @(posedge ref_clk);
        rd(8'h0c, 32'h0);
        rd(8'h10, 32'h0);
        for (i = 0; i < 4; i++)
        begin
            wr(8'h00, i);
            rd(8'h04, 32'h0);
            wr(8'h08, i);
            st[i] = 3'h0;
        end
        // unmapped place answers with an error and zero data
        apb(1'h0, 8'h14, 32'h0);
        chk(q, 32'h0);
        chk(e, 32'h1);
        wr(8'h0c, 32'hf);
        for (i = 0; i < 4; i++)
        begin
            ev(2'h1, i[1:0]);
            wr(8'h00, i);
            rd(8'h04, 32'h2);
            chk(out_nack, 32'h1);
            chk(irq, 32'h1);
            rd(8'h10, 32'h1 << i);
            ev(2'h1, i[1:0]);
            ev(2'h0, i[1:0]);
            rd(8'h04, 32'h4);
            chk(out_nack, 32'h0);
            wr(8'h04, 32'h3);
            rd(8'h04, 32'h0);
            ev(2'h1, i[1:0]);
            ev(2'h2, i[1:0]);
            rd(8'h04, (i == 1) ? 32'h3 : 32'h2);
            ev(2'h3, i[1:0]);
            rd(8'h04, 32'h3);
            wr(8'h04, 32'h5);
            rd(8'h04, 32'h1);
            chk(out_nack, 32'h0);
            wr(8'h04, 32'h0);
            wr(8'h10, 32'hf);
            rd(8'h10, 32'h0);
            chk(irq, 32'h0);
        end
        // masked: events and firmware clears at random
        wr(8'h0c, 32'h0);
        for (n = 0; n < 60; n++)
        begin
            r = $random(seed);
            x = r[3:2];
            if (r[6:4] == 3'h0)
            begin
                wr(8'h00, x);
                wr(8'h04, r[10:8]);
                st[x] = st[x] & r[10:8];
            end
            else
            begin
                ev(r[1:0], x);
                st[x] = fx(st[x], r[1:0], x);
                chk(out_nack, st[x][1]);
                wr(8'h00, x);
            end
            rd(8'h04, st[x]);
        end
        chk(irq, 32'h0);
        rd(8'h10, 32'h0);
        // mid-run reset with flags standing clears them all
        wr(8'h0c, 32'hf);
        ev(2'h0, 2'h3);
        chk(irq, 32'h1);
        arst_n <= 1'h0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'h1;
        @(posedge ref_clk);
        chk(irq, 32'h0);
        chk(out_nack, 32'h0);
        rd(8'h0c, 32'h0);
        rd(8'h10, 32'h0);
        for (i = 0; i < 4; i++)
        begin
            wr(8'h00, i);
            rd(8'h04, 32'h0);
        end
        tally_and_finish();
    end
endmodule
